// ==== htb_bridge.sv ====
// Head tracker channel bridge: records in, 16 channels out, APB registers
`timescale 1ns/1ps
module htb_bridge
    import htb_pkg::*;
#(
    parameter int unsigned LONG_CYC  = LONG_PRESS_CYC,
    parameter int unsigned BLINK_CYC = BLINK_HALF_CYC,
    parameter int unsigned IDLE_CYC  = IDLE_TIMEOUT_CYC
) (
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire htb_record_t record,
    input  wire logic        recordValid,
    input  wire logic        buttonPin,
    input  wire logic        boresightPin,
    input  wire logic        typeSwitchPin,
    input  wire logic        fiberLinkPin,
    output htb_sample_t      sample,
    output logic             trackerTypeB,
    output logic             cmdBoresight,
    output logic             cmdReset,
    output logic             activeLed,
    output logic             dataLed,
    output logic             firstReceiverIndicator,
    output logic             secondReceiverIndicator,
    output logic             irq
);
    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [3:0] pinMeta_q;
    logic [3:0] pinSync_q;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pinMeta_q <= 4'h0;
            pinSync_q <= 4'h0;
        end else begin
            pinMeta_q <= {fiberLinkPin, typeSwitchPin, boresightPin,
                          buttonPin};
            pinSync_q <= pinMeta_q;
        end
    end
    logic btnLvl;
    logic extLvl;
    logic typeLvl;
    logic linkLvl;
    assign btnLvl  = pinSync_q[0];
    assign extLvl  = pinSync_q[1];
    assign typeLvl = pinSync_q[2];
    assign linkLvl = pinSync_q[3];

    // ****************************************************************
    // Tracker type capture
    // ****************************************************************
    // Wait past the synchroniser so the latched value is the real switch
    logic [1:0] typeWait_q;
    logic       typeB_q;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            typeWait_q <= 2'h0;
            typeB_q    <= 1'b0;
        end else if (typeWait_q != 2'h3) begin
            typeWait_q <= typeWait_q + 2'h1;
            if (typeWait_q == 2'h2) begin
                typeB_q <= typeLvl;
            end
        end
    end
    assign trackerTypeB = typeB_q;

    // ****************************************************************
    // Register file
    // ****************************************************************
    logic [2:0]  ctrl_q;
    logic [3:0]  intStat_q;
    logic [3:0]  intMask_q;
    logic [3:0]  events;
    logic        pready_q;
    logic [31:0] prdata_q;
    logic        pslverr_q;
    logic        wrDone;
    logic        swBore;
    logic        swReset;
    logic [1:0]  rxActive;
    logic        linkUp_q;

    function automatic logic mapped(input logic [11:0] a);
        mapped = (a == ADDR_CTRL) || (a == ADDR_STATUS) ||
                 (a == ADDR_INT_STAT) || (a == ADDR_INT_MASK);
    endfunction : mapped

    assign wrDone  = psel && penable && pready_q && pwrite;
    assign swBore  = wrDone && (paddr == ADDR_CTRL) &&
                     pwdata[CTRL_BORE_BIT];
    assign swReset = wrDone && (paddr == ADDR_CTRL) &&
                     pwdata[CTRL_RESET_BIT];

    // One wait-free access phase: answer is ready in the access cycle
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= psel && !penable;
            pslverr_q <= psel && !penable && !mapped(paddr);
            if (psel && !penable && !pwrite) begin
                if (paddr == ADDR_CTRL) begin
                    prdata_q <= {29'h0, ctrl_q};
                end else if (paddr == ADDR_STATUS) begin
                    prdata_q <= {27'h0, rxActive, linkUp_q, typeB_q,
                                 1'b0};
                end else if (paddr == ADDR_INT_STAT) begin
                    prdata_q <= {28'h0, intStat_q};
                end else if (paddr == ADDR_INT_MASK) begin
                    prdata_q <= {28'h0, intMask_q};
                end else begin
                    prdata_q <= 32'h0000_0000;
                end
            end
        end
    end
    assign pready  = pready_q;
    assign prdata  = prdata_q;
    assign pslverr = pslverr_q;

    // Command bits self-clear; only the send enable is stored
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q    <= CTRL_RESET_VAL;
            intMask_q <= MASK_RESET_VAL;
        end else if (wrDone) begin
            if (paddr == ADDR_CTRL) begin
                ctrl_q <= {pwdata[CTRL_SEND_BIT], 2'h0};
            end else if (paddr == ADDR_INT_MASK) begin
                intMask_q <= pwdata[3:0];
            end
        end
    end

    // Set beats write-one-to-clear in the same cycle
    logic [3:0] clrBits;
    assign clrBits = (wrDone && paddr == ADDR_INT_STAT) ? pwdata[3:0]
                                                        : 4'h0;
    logic irq_q;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            intStat_q <= 4'h0;
            irq_q     <= 1'b0;
        end else begin
            intStat_q <= (intStat_q & ~clrBits) | events;
            irq_q     <= |(((intStat_q & ~clrBits) | events) & intMask_q);
        end
    end
    assign irq = irq_q;

    // ****************************************************************
    // Button and external boresight
    // ****************************************************************
    logic [31:0] btnCnt_q;
    logic        btnLong_q;
    logic        btnBore;
    logic        btnReset;
    assign btnReset = btnLvl && !btnLong_q && (btnCnt_q == LONG_CYC - 1);
    assign btnBore  = !btnLvl && !btnLong_q && (btnCnt_q >= PULSE_MIN_CYC);
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            btnCnt_q  <= 32'h0;
            btnLong_q <= 1'b0;
        end else if (btnLvl) begin
            if (!btnLong_q) begin
                btnCnt_q <= btnCnt_q + 32'h1;
            end
            if (btnReset) begin
                btnLong_q <= 1'b1;
            end
        end else begin
            btnCnt_q  <= 32'h0;
            btnLong_q <= 1'b0;
        end
    end

    logic [3:0] extCnt_q;
    logic       extArmed_q;
    logic       extBore;
    assign extBore = extLvl && extArmed_q && (extCnt_q == PULSE_MIN_CYC - 1);
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            extCnt_q   <= 4'h0;
            extArmed_q <= 1'b0;
        end else if (extLvl != extArmed_q) begin
            // Level opposite to the armed state: restart the count from zero
            extCnt_q <= 4'h0;
        end else if (extCnt_q == PULSE_MIN_CYC - 1) begin
            extCnt_q   <= 4'h0;
            extArmed_q <= !extArmed_q;
        end else begin
            extCnt_q <= extCnt_q + 4'h1;
        end
    end

    logic cmdBore_q;
    logic cmdReset_q;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cmdBore_q  <= 1'b0;
            cmdReset_q <= 1'b0;
        end else begin
            cmdBore_q  <= btnBore || extBore || swBore;
            cmdReset_q <= btnReset || swReset;
        end
    end
    assign cmdBoresight = cmdBore_q;
    assign cmdReset     = cmdReset_q;

    // ****************************************************************
    // Channel store
    // ****************************************************************
    logic [15:0] chan_q [NUM_CHAN];
    logic [3:0]  base;
    assign base = record.rx ? CH_RX2_BASE : CH_RX1_BASE;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                chan_q[i] <= 16'h0000;
            end
        end else if (recordValid) begin
            for (int i = 0; i < 3; i++) begin
                chan_q[base + 4'(i)] <=
                    record.orientationTriplet[i];
                chan_q[base + 4'(i + 3)] <=
                    record.position[i];
            end
            for (int i = 0; i < 4; i++) begin
                // ASCII times two reads back as ASCII after 16384.2
                chan_q[CH_ERR_BASE + 4'(i)] <= typeB_q ? 16'h0000 :
                    {7'h00, record.errChars[i], 1'b0};
            end
        end
    end

    // ****************************************************************
    // Fiber sample stream
    // ****************************************************************
    logic [31:0]  frameCnt_q;
    logic         sending_q;
    logic [3:0]   sendIdx_q;
    htb_sample_t  sample_q;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            frameCnt_q <= 32'h0;
        end else if (frameCnt_q == FRAME_CYC - 1) begin
            frameCnt_q <= 32'h0;
        end else begin
            frameCnt_q <= frameCnt_q + 32'h1;
        end
    end
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sending_q <= 1'b0;
            sendIdx_q <= 4'h0;
            sample_q  <= '0;
        end else begin
            if (frameCnt_q == 32'h0 && linkUp_q && ctrl_q[CTRL_SEND_BIT]) begin
                sending_q <= 1'b1;
                sendIdx_q <= 4'h0;
            end else if (sending_q) begin
                sendIdx_q <= sendIdx_q + 4'h1;
                sending_q <= sendIdx_q != 4'hF;
            end
            sample_q.valid <= sending_q;
            sample_q.index <= sendIdx_q;
            sample_q.data  <= chan_q[sendIdx_q];
        end
    end
    assign sample = sample_q;

    // ****************************************************************
    // Activity and indicators
    // ****************************************************************
    logic [31:0] rxAge_q [NUM_RX];
    generate
        for (genvar r = 0; r < NUM_RX; r++) begin : g_rx
            always_ff @(posedge sys_clk or negedge reset_n) begin
                if (!reset_n) begin
                    rxAge_q[r] <= IDLE_CYC;
                end else if (recordValid && record.rx == 1'(r)) begin
                    rxAge_q[r] <= 32'h0;
                end else if (rxAge_q[r] < IDLE_CYC) begin
                    rxAge_q[r] <= rxAge_q[r] + 32'h1;
                end
            end
            assign rxActive[r] = rxAge_q[r] < IDLE_CYC;
        end
    endgenerate

    logic [31:0] blinkCnt_q;
    logic        blink_q;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            blinkCnt_q <= 32'h0;
            blink_q    <= 1'b0;
        end else if (blinkCnt_q == BLINK_CYC - 1) begin
            blinkCnt_q <= 32'h0;
            blink_q    <= !blink_q;
        end else begin
            blinkCnt_q <= blinkCnt_q + 32'h1;
        end
    end

    logic activeLed_q;
    logic dataLed_q;
    logic rx1Led_q;
    logic rx2Led_q;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            linkUp_q    <= 1'b0;
            activeLed_q <= 1'b0;
            dataLed_q   <= 1'b0;
            rx1Led_q    <= 1'b0;
            rx2Led_q    <= 1'b0;
        end else begin
            linkUp_q    <= linkLvl;
            activeLed_q <= linkUp_q ? 1'b1 : blink_q;
            dataLed_q   <= (|rxActive) ? 1'b1 : blink_q;
            rx1Led_q    <= rxActive[0];
            rx2Led_q    <= rxActive[1];
        end
    end
    assign activeLed               = activeLed_q;
    assign dataLed                 = dataLed_q;
    assign firstReceiverIndicator  = rx1Led_q;
    assign secondReceiverIndicator = rx2Led_q;

    assign events[EV_RECORD]    = recordValid;
    assign events[EV_BORESIGHT] = cmdBore_q;
    assign events[EV_RESET]     = cmdReset_q;
    assign events[EV_LINK_LOST] = linkUp_q && !linkLvl;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    // Ten high cycles are split as eight plus two to keep repetition short
    sequence extHigh8;
        extLvl [*8];
    endsequence
    short_press_a: assert property (
        btnBore |=> cmdBoresight && !cmdReset)
        else $error("short press gave no boresight");
    long_press_a: assert property (
        btnLvl && btnCnt_q == LONG_CYC - 1 && !btnLong_q |=> cmdReset)
        else $error("long press gave no reset");
    ext_pulse_a: assert property (
        !extLvl ##1 extHigh8 ##1 extLvl [*2] ##0 extArmed_q |=> cmdBoresight)
        else $error("external pulse missed");
    ext_rearm_a: assert property (
        extBore |=> !extArmed_q [*2])
        else $error("external input rearmed too soon");
    active_blink_a: assert property (
        !linkUp_q && $changed(blink_q) |=> activeLed == blink_q)
        else $error("active led not blinking");
    data_led_a: assert property (
        recordValid |-> ##2 dataLed)
        else $error("data led off after record");
    rx_led_a: assert property (
        recordValid && record.rx |-> ##2 secondReceiverIndicator)
        else $error("second receiver led off");
    type_hold_a: assert property (
        typeWait_q == 2'h3 |=> $stable(trackerTypeB))
        else $error("tracker type changed after capture");
    frame_len_a: assert property (
        sample.valid && sample.index == 4'hF |=> !sample.valid [*8])
        else $error("frame overran sixteen channels");
    chan_store_a: assert property (
        recordValid && !record.rx |=>
        chan_q[0] == $past(record.orientationTriplet[0]))
        else $error("receiver one azimuth not stored");
    err_zero_a: assert property (
        recordValid && typeB_q |=> chan_q[12] == 16'h0000)
        else $error("error channel not zero for type B");
endmodule : htb_bridge

// ==== htb_pkg.sv ====
// Shared constants and types for the head tracker channel bridge
package htb_pkg;
    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned CLK_PERIOD_NS   = 20;
    localparam int unsigned LONG_PRESS_MS   = 1000;
    localparam int unsigned LONG_PRESS_CYC  = CLK_HZ / 1000 * LONG_PRESS_MS;
    localparam int unsigned BLINK_HZ        = 1;
    localparam int unsigned BLINK_HALF_CYC  = CLK_HZ / (2 * BLINK_HZ);
    localparam int unsigned PULSE_MIN_NS    = 200;
    localparam int unsigned PULSE_MIN_CYC   =
        (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SAMPLE_RATE_HZ  = 25_000;
    localparam int unsigned FRAME_CYC       = CLK_HZ / SAMPLE_RATE_HZ;
    localparam int unsigned IDLE_TIMEOUT_MS = 100;
    localparam int unsigned IDLE_TIMEOUT_CYC =
        CLK_HZ / 1000 * IDLE_TIMEOUT_MS;

    // ****************************************************************
    // Channel layout
    // ****************************************************************
    localparam int unsigned NUM_CHAN       = 16;
    localparam int unsigned NUM_RX         = 2;
    localparam logic [3:0]  CH_RX1_BASE    = 4'h0;
    localparam logic [3:0]  CH_RX2_BASE    = 4'h6;
    localparam logic [3:0]  CH_ERR_BASE    = 4'hC;

    // ****************************************************************
    // Register map (byte addresses) and fields
    // ****************************************************************
    localparam logic [11:0] ADDR_CTRL      = 12'h000;
    localparam logic [11:0] ADDR_STATUS    = 12'h004;
    localparam logic [11:0] ADDR_INT_STAT  = 12'h008;
    localparam logic [11:0] ADDR_INT_MASK  = 12'h00C;
    localparam int unsigned CTRL_BORE_BIT  = 0;
    localparam int unsigned CTRL_RESET_BIT = 1;
    localparam int unsigned CTRL_SEND_BIT  = 2;
    localparam logic [2:0]  CTRL_RESET_VAL = 3'h4;
    localparam logic [3:0]  MASK_RESET_VAL = 4'h0;
    localparam int unsigned EV_RECORD      = 0;
    localparam int unsigned EV_BORESIGHT   = 1;
    localparam int unsigned EV_RESET       = 2;
    localparam int unsigned EV_LINK_LOST   = 3;

    // One parsed tracker record
    typedef struct packed {
        logic             rx;
        logic [2:0][15:0] orientationTriplet;
        logic [2:0][15:0] position;
        logic [3:0][7:0]  errChars;
    } htb_record_t;

    // One sample on the fiber side
    typedef struct packed {
        logic        valid;
        logic [3:0]  index;
        logic [15:0] data;
    } htb_sample_t;
endpackage : htb_pkg

// ==== htb_base_model.sv ====
// Base station model: gathers fiber samples into a channel image
`timescale 1ns/1ps
module htb_base_model
    import htb_pkg::*;
(
    input  wire logic         sys_clk,
    input  wire logic         linkOn,
    input  wire htb_sample_t  sample,
    output logic              fiberLinkPin,
    output logic [15:0][15:0] chanImage,
    output int                frameCnt
);
    // ****************
    // Link and capture
    // ****************
    // Raw words kept; full-scale scaling is left to software
    assign fiberLinkPin = linkOn;
    initial frameCnt = 0;
    always @(posedge sys_clk) begin
        if (sample.valid === 1'b1) begin
            chanImage[sample.index] <= sample.data;
            if (sample.index === 4'hF) begin
                frameCnt <= frameCnt + 1;
            end
        end
    end
endmodule : htb_base_model

// ==== tb_top.sv ====
// Self-checking bench for the head tracker channel bridge
`timescale 1ns/1ps
module tb_top
    import htb_pkg::*;
;
    logic              sys_clk, reset_n, psel, penable, pwrite, pready;
    logic [11:0]       paddr;
    logic [31:0]       pwdata, prdata, rd, seed;
    logic              pslverr, err, recordValid, buttonPin, boresightPin;
    logic              typeSwitchPin, fiberLinkPin, linkOn, trackerTypeB;
    logic              cmdBoresight, cmdReset, activeLed, dataLed, irq;
    logic              firstReceiverIndicator, secondReceiverIndicator;
    logic              prevA, prevD, expTypeB;
    htb_record_t       record;
    htb_sample_t       sample;
    logic [15:0][15:0] chanImage;
    logic [15:0]       expCh [16];
    int                frameCnt, error_cnt, checked, boreCnt, resetCnt;
    int                i, togA, togD;

    htb_bridge #(.LONG_CYC(200), .BLINK_CYC(20), .IDLE_CYC(100)) DUT (
        .sys_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .prdata, .pslverr, .record, .recordValid, .buttonPin,
        .boresightPin, .typeSwitchPin, .fiberLinkPin, .sample,
        .trackerTypeB, .cmdBoresight, .cmdReset, .activeLed, .dataLed,
        .firstReceiverIndicator, .secondReceiverIndicator, .irq);
    htb_base_model BASE (.sys_clk, .linkOn, .sample, .fiberLinkPin,
        .chanImage, .frameCnt);

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (cmdBoresight === 1'b1) boreCnt <= boreCnt + 1;
        if (cmdReset === 1'b1) resetCnt <= resetCnt + 1;
    end

    // ****************
    // Helpers
    // ****************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t %s %h/%h", $time, what, got, exp);
        end
    endtask : chk
    task automatic report_and_stop;
        if (error_cnt == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : report_and_stop
    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk);
    endtask : cyc
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge sys_clk);
            if (pready === 1'b1) break;
        end
        if (n == 16) begin
            chk(32'h0, 32'h1, "apb wait");
            report_and_stop();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Caller lowers the strobe, so records may run back to back
    task automatic sendRec(input logic rx);
        int k;
        record.rx <= rx;
        for (k = 0; k < 3; k++) begin
            seed = lfsr(seed);
            record.orientationTriplet[k] <= seed[15:0];
            record.position[k] <= seed[31:16];
            expCh[(rx ? 6 : 0) + k] = seed[15:0];
            expCh[(rx ? 9 : 3) + k] = seed[31:16];
        end
        for (k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            record.errChars[k] <= seed[7:0];
            expCh[12 + k] = expTypeB ? 16'h0000 : {7'h00, seed[7:0], 1'b0};
        end
        recordValid <= 1'b1;
        @(posedge sys_clk);
    endtask : sendRec
    task automatic frames(input int k, input int want);
        int f, n;
        f = frameCnt;
        for (n = 0; n < 2100 * k && frameCnt - f < k; n++) begin
            @(posedge sys_clk);
        end
        chk(32'(frameCnt - f), 32'(want), "frame count");
        if (frameCnt - f < want) report_and_stop();
    endtask : frames
    task automatic pulse(input int hi, input int lo);
        boresightPin <= 1'b1;
        cyc(hi);
        boresightPin <= 1'b0;
        cyc(lo);
    endtask : pulse
    task automatic chans;
        int c;
        for (c = 0; c < 16; c++) begin
            chk(32'(chanImage[c]), 32'(expCh[c]), "chan");
        end
    endtask : chans

    // ****************
    // Main sequence
    // ****************
    initial begin
        {psel, penable, pwrite, recordValid, buttonPin} = '0;
        {boresightPin, typeSwitchPin, reset_n} = '0;
        {paddr, pwdata, record} = '0;
        {error_cnt, checked, boreCnt, resetCnt} = '0;
        linkOn = 1'b1;
        expTypeB = 1'b0;
        seed = 32'hABB5;
        repeat (8) @(posedge sys_clk);
        reset_n <= 1'b1;
        cyc(4);
        typeSwitchPin <= 1'b1;
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk(rd, {29'h0, CTRL_RESET_VAL}, "ctrl reset");
        apb(1'b0, ADDR_INT_MASK, 32'h0);
        chk(rd, {28'h0, MASK_RESET_VAL}, "mask reset");
        apb(1'b1, 12'h010, 32'hFFFF_FFFF);
        chk(32'(err), 32'h1, "unmapped write");
        apb(1'b0, 12'h010, 32'h0);
        chk({rd[30:0], err}, 32'h1, "unmapped read");
        apb(1'b1, ADDR_INT_MASK, 32'h1);
        sendRec(1'b0);
        sendRec(1'b1);
        recordValid <= 1'b0;
        cyc(2);
        chk(32'({dataLed, firstReceiverIndicator, secondReceiverIndicator}),
            32'h7, "indicators");
        chk(32'(irq), 32'h1, "irq raised");
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd, 32'h1C, "status");
        apb(1'b1, ADDR_INT_STAT, 32'h1);
        cyc(2);
        chk(32'(irq), 32'h0, "irq cleared");
        frames(2, 2);
        chans();
        chk(32'(trackerTypeB), 32'h0, "type held");
        buttonPin <= 1'b1;
        cyc(20);
        buttonPin <= 1'b0;
        cyc(10);
        chk(32'(boreCnt), 32'h1, "short press");
        buttonPin <= 1'b1;
        cyc(220);
        buttonPin <= 1'b0;
        cyc(10);
        chk(32'(boreCnt + 2 * resetCnt), 32'h3, "long press");
        pulse(15, 3);
        pulse(15, 15);
        chk(32'(boreCnt), 32'h2, "short gap");
        pulse(15, 5);
        chk(32'(boreCnt), 32'h3, "rearmed");
        apb(1'b1, ADDR_CTRL, 32'h5);
        apb(1'b1, ADDR_CTRL, 32'h6);
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk(rd, 32'h4, "ctrl pulses read 0");
        chk(32'(boreCnt + 2 * resetCnt), 32'h8, "ctrl commands");
        chk(32'(irq), 32'h0, "irq masked");
        apb(1'b0, ADDR_INT_STAT, 32'h0);
        chk(rd, 32'h6, "events");
        linkOn <= 1'b0;
        cyc(4);
        {togA, togD, prevA, prevD} = {32'h0, 32'h0, activeLed, dataLed};
        for (i = 0; i < 100; i++) begin
            @(posedge sys_clk);
            togA += int'(activeLed !== prevA);
            togD += int'(dataLed !== prevD);
            {prevA, prevD} = {activeLed, dataLed};
        end
        chk(32'(togA > 3), 32'h1, "active blink");
        chk(32'(togD > 3), 32'h1, "data blink");
        frames(1, 0);
        apb(1'b0, ADDR_INT_STAT, 32'h0);
        chk(rd & 32'h8, 32'h8, "link lost");
        // Mid-run reset with the switch now at the second type
        reset_n <= 1'b0;
        cyc(2);
        reset_n <= 1'b1;
        linkOn <= 1'b1;
        expTypeB = 1'b1;
        for (i = 0; i < 16; i++) begin
            expCh[i] = 16'h0000;
        end
        cyc(4);
        chk(32'(trackerTypeB), 32'h1, "type captured");
        sendRec(1'b0);
        recordValid <= 1'b0;
        frames(2, 2);
        chans();
        report_and_stop();
    end
    initial begin
        repeat (100000) @(posedge sys_clk);
        chk(32'h0, 32'h1, "run limit");
        report_and_stop();
    end
endmodule : tb_top
